// ### dv/ikt_key_matrix.sv
/*
 * Key switch matrix model: one key group closed on one digit line.
 * Assumes digit_line is one-hot from the block; key pins have pull-downs.
 */
`timescale 1ns/1ps
module ikt_key_matrix import ikt_pkg::*; (
  input  wire logic [DIGITS-1:0] digit_line,
  input  wire logic              press_on,
  input  wire logic [DIG_W-1:0]  press_digit,
  input  wire logic [NIB_W-1:0]  press_keys,
  output logic [NIB_W-1:0]       key_line
);
  // Open switch or idle digit leaves the pins on their pull-downs
  assign key_line = (press_on && digit_line[press_digit]) ? press_keys : 4'h0;
endmodule

// ### dv/ikt_ports_test.sv
/*
 * Self-checking bench for the internal port block with a key matrix model.
 * Assumes the time base prescaler is shortened to 10 cycles per tick.
 */
`timescale 1ns/1ps
module ikt_ports_test import ikt_pkg::*;;
  logic                clock, rst, clock_stop_instr, indirect_move, program_word_lookup;
  logic                inhibit_pin, press_on;
  ikt_port_req_s       port_req;
  logic [NIB_W-1:0]    port_rdata, row_address, mem_low_addr, key_line, factory_test_port;
  logic [NIB_W-1:0]    press_keys, rv;
  logic [WORD_W-1:0]   program_word;
  logic [DIGITS-1:0]   digit_line;
  logic [DIG_W-1:0]    press_digit;
  int                  mismatches, checks, i, n;

  ikt_ports #(.TICK_CYC(10)) dut (.clock(clock), .rst(rst),
    .clock_stop_instr(clock_stop_instr), .port_req(port_req), .port_rdata(port_rdata),
    .indirect_move(indirect_move), .row_address(row_address), .mem_low_addr(mem_low_addr),
    .program_word_lookup(program_word_lookup), .program_word(program_word),
    .key_line(key_line), .digit_line(digit_line), .inhibit_pin(inhibit_pin),
    .factory_test_port(factory_test_port));

  ikt_key_matrix keys (.digit_line(digit_line), .press_on(press_on),
    .press_digit(press_digit), .press_keys(press_keys), .key_line(key_line));

  always #5 clock = ~clock;

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task wr(input logic key, input logic [3:0] code, input logic [3:0] d);
    @(posedge clock);
    port_req <= {!key, 1'b0, key, 1'b0, code, d};
    @(posedge clock);
    port_req <= '0;
  endtask

  task rd(input logic key, input logic [3:0] code);
    @(posedge clock);
    port_req <= {1'b0, !key, 1'b0, key, code, 4'h0};
    @(posedge clock);
    port_req <= '0;
    #1;
    rv = port_rdata;
  endtask

  // Polls the status port; each poll costs two cycles
  task wait_bit(input int b, input logic v, input int lim);
    n = 0;
    rd(0, CN_CTRL);
    while (rv[b] !== v) begin
      n++;
      if (n > lim) begin
        $display("ERROR at %0t: status wait expired", $time);
        mismatches++;
        wrap_up();
      end
      rd(0, CN_CTRL);
    end
  endtask

  initial begin
    clock = 0;
    rst = 1;
    clock_stop_instr = 0;
    port_req = '0;
    indirect_move = 0;
    row_address = 4'h0;
    program_word_lookup = 0;
    program_word = 16'h0;
    inhibit_pin = 0;
    press_on = 0;
    press_digit = 3'h0;
    press_keys = 4'h0;
    mismatches = 0;
    checks = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk(port_rdata, 16'h0);
    chk(factory_test_port, 16'h0);
    for (i = 0; i < 8; i++) begin
      row_address <= 4'hf - i[3:0];
      wr(0, CN_INDIR, i[3:0]);
      #1;
      chk(mem_low_addr, 16'hf - i);
      indirect_move <= 1'b1;
      @(posedge clock);
      #1;
      chk(mem_low_addr, i);
      indirect_move <= 1'b0;
    end
    @(posedge clock);
    program_word <= 16'hc3a5;
    program_word_lookup <= 1'b1;
    @(posedge clock);
    program_word_lookup <= 1'b0;
    program_word <= 16'h0;
    for (i = 0; i < 4; i++) begin
      rd(1, 4'h4 + i[3:0]);
      chk(rv, (16'hc3a5 >> (4 * i)) & 16'hf);
    end
    inhibit_pin <= 1'b1;
    repeat (6) @(posedge clock);
    wr(0, CN_CTRL, 4'h1);
    rd(0, CN_INH);
    chk(rv, 16'h1);
    inhibit_pin <= 1'b0;
    repeat (6) @(posedge clock);
    rd(0, CN_INH);
    chk(rv, 16'h1);
    wr(0, CN_CTRL, 4'h1);
    rd(0, CN_INH);
    chk(rv, 16'h0);
    wr(0, CN_SEL_LO, 4'hf);
    wr(0, CN_SEL_HI, 4'h7);
    #1;
    chk(factory_test_port, 16'h0);
    rd(0, CN_SEL_LO);
    chk(rv, 16'hf);
    press_on <= 1'b1;
    press_digit <= 3'h2;
    press_keys <= 4'h9;
    wr(0, CN_CTRL, 4'h4);
    rd(0, CN_CTRL);
    chk(rv[ST_KEY_ON], 16'h0);
    wait_bit(ST_KEY_ON, 1'b1, 100);
    rd(1, CN_KEYLAT);
    chk(rv, 16'h9);
    rd(1, CN_RES_LO);
    chk(rv, 16'h4);
    press_digit <= 3'h5;
    press_keys <= 4'h6;
    repeat (100) @(posedge clock);
    rd(1, CN_KEYLAT);
    chk(rv, 16'h9);
    rd(1, CN_RES_HI);
    chk(rv, 16'h0);
    wr(0, CN_SEL_LO, 4'h1);
    wr(0, CN_SEL_HI, 4'h0);
    wr(0, CN_CTRL, 4'h4);
    repeat (150) @(posedge clock);
    rd(0, CN_CTRL);
    chk(rv[ST_KEY_ON], 16'h0);
    press_digit <= 3'h0;
    wait_bit(ST_KEY_ON, 1'b1, 100);
    rd(1, CN_KEYLAT);
    chk(rv, 16'h6);
    rd(1, CN_RES_LO);
    chk(rv, 16'h1);
    wait_bit(ST_10HZ, 1'b0, 60);
    wr(0, CN_CTRL, 4'h8);
    rd(0, CN_CTRL);
    chk(rv[ST_10HZ], 16'h1);
    @(posedge clock);
    port_req <= {1'b0, 1'b1, 2'b00, CN_CTRL, 4'h0};
    n = 0;
    repeat (100) begin
      @(posedge clock);
      #1;
      n += port_rdata[ST_10HZ];
    end
    port_req <= '0;
    chk(n[15:0], 16'd60);
    wait_bit(ST_10HZ, 1'b0, 60);
    clock_stop_instr <= 1'b1;
    @(posedge clock);
    clock_stop_instr <= 1'b0;
    rd(0, CN_CTRL);
    chk(rv[ST_10HZ], 16'h1);
    // Timer is cleared before any look, its state after stop is unknown
    wr(0, CN_CTRL, 4'h2);
    rd(0, CN_CTRL);
    chk(rv[ST_TMR], 16'h0);
    wait_bit(ST_TMR, 1'b1, 260);
    rd(0, CN_CTRL);
    chk(rv[ST_TMR], 16'h1);
    wr(0, CN_CTRL, 4'h2);
    repeat (400) @(posedge clock);
    rd(0, CN_CTRL);
    chk(rv[ST_TMR], 16'h0);
    wait_bit(ST_TMR, 1'b1, 100);
    wr(1, CN_TEST, 4'h0);
    #1;
    chk(factory_test_port, 16'h0);
    wrap_up();
  end
endmodule

// ### inc/ikt_pkg.sv
/*
 * Shared constants and types for the internal port, key scan and time base block.
 * Assumes a 100 MHz instruction clock and a CPU that issues one port access per cycle.
 */
package ikt_pkg;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int NS_PER_MS      = 1000000;
  localparam int TICK_MS        = 10;
  localparam int TICK_CYCLES    = TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int PERIOD_10HZ_MS = 100;
  localparam int DUTY_10HZ_PCT  = 60;
  localparam int PCT_FULL       = 100;
  localparam int TICKS_10HZ     = PERIOD_10HZ_MS / TICK_MS;
  localparam int HIGH_10HZ      = TICKS_10HZ * DUTY_10HZ_PCT / PCT_FULL;
  localparam int PERIOD_2HZ_MS  = 500;
  localparam int TICKS_2HZ      = PERIOD_2HZ_MS / TICK_MS;

  localparam int PRE_W   = 20;
  localparam int TB_W    = 6;
  localparam int NIB_W   = 4;
  localparam int DIGITS  = 7;
  localparam int DIG_W   = 3;
  localparam int WORD_W  = 16;

  // Digit scan: last cycle of a slot and the strobe position; the strobe waits
  // for the key synchroniser so it samples this slot's key, not the last one
  localparam logic [2:0] DIGIT_LAST = 3'h5;
  localparam logic [2:0] DIGIT_MID  = 3'h4;
  localparam logic [2:0] DIGIT_MAX  = 3'h6;

  // Operand codes
  localparam logic [3:0] CN_RES_LO  = 4'h0;
  localparam logic [3:0] CN_RES_HI  = 4'h1;
  localparam logic [3:0] CN_KEYLAT  = 4'h2;
  localparam logic [3:0] CN_INDIR   = 4'h4;
  localparam logic [3:0] CN_INH     = 4'h4;
  localparam logic [3:0] CN_CTRL    = 4'h5;
  localparam logic [3:0] CN_SEL_LO  = 4'h6;
  localparam logic [3:0] CN_SEL_HI  = 4'h7;
  localparam logic [3:0] CN_TEST    = 4'h7;
  localparam logic [1:0] DREG_HI2   = 2'h1;

  // Control port bits (write) and status port bits (read)
  localparam int BIT_INH_CAP  = 0;
  localparam int BIT_TMR_CLR  = 1;
  localparam int BIT_KEY_RST  = 2;
  localparam int BIT_CLK_RST  = 3;
  localparam int ST_KEY0      = 0;
  localparam int ST_KEY_ON    = 1;
  localparam int ST_TMR       = 2;
  localparam int ST_10HZ      = 3;

  typedef enum logic [1:0] {KS_IDLE, KS_SAMPLE, KS_CHECK, KS_HOLD} ikt_scan_e;

  typedef struct packed {
    logic       io_out;
    logic       io_in;
    logic       key_out;
    logic       key_in;
    logic [3:0] code;
    logic [3:0] wdata;
  } ikt_port_req_s;
endpackage

// ### verilog/ikt_ports.sv
/*
 * Internal ports of the tuning controller: key scan latch, indirect address
 * register, program word data register, inhibit latch, timer flag, test port.
 * Assumes the CPU raises one port strobe per cycle with the operand code and
 * data, and that key lines and the inhibit pin are asynchronous pins.
 */
// Behaviour
// - Select digits, then restart starts key sampling
// - Latch nonzero key at selected digit, stop
// - Then check all digits, set key-pressed
// - Hold key and results until next restart
// - Indirect register gives low address for moves
// - Indirect register written by output code 4
// - Indirect value used only during indirect moves
// - Values zero to fifteen reach every address
// - Lookup instruction loads 16-bit program word
// - Key input codes 4-7 read nibbles
// - Input code 4 reads inhibit latch
// - Inhibit capture bit refreshes latch from pin
// - Timer flag set each 500 ms, cleared
// - Timer flag cleared only by clear bit
// - Timer value undefined after power or stop
// - 10 Hz pulse, 60 % duty, unlatched
// - Clock reset clears sub-50 Hz divider stages
// - Restart also clears key-pressed flag
// - Select bit per digit enables capture
`timescale 1ns/1ps
module ikt_ports import ikt_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                clock_stop_instr,
  input  wire ikt_port_req_s       port_req,
  output logic [NIB_W-1:0]         port_rdata,
  input  wire logic                indirect_move,
  input  wire logic [NIB_W-1:0]    row_address,
  output logic [NIB_W-1:0]         mem_low_addr,
  input  wire logic                program_word_lookup,
  input  wire logic [WORD_W-1:0]   program_word,
  input  wire logic [NIB_W-1:0]    key_line,
  output logic [DIGITS-1:0]        digit_line,
  input  wire logic                inhibit_pin,
  output logic [NIB_W-1:0]         factory_test_port
);
  typedef struct packed {
    logic [NIB_W-1:0]  key_s1;
    logic [NIB_W-1:0]  key_s2;
    logic [NIB_W-1:0]  key_s3;
    logic [NIB_W-1:0]  key_f;
    logic              inh_s1;
    logic              inh_s2;
    logic              inh_s3;
    logic              inh_f;
    logic [2:0]        cyc;
    logic [DIG_W-1:0]  dig;
    logic [DIGITS-1:0] digit_out;
    ikt_scan_e         st;
    logic [DIG_W-1:0]  chk_cnt;
    logic [NIB_W-1:0]  key_val;
    logic [DIGITS-1:0] result;
    logic              key_on;
    logic [DIGITS-1:0] sel;
    logic [NIB_W-1:0]  indirect_low_address_reg;
    logic [WORD_W-1:0] program_word_data_reg;
    logic              inhibit_input_latch;
    logic              timer_2hz;
    logic [NIB_W-1:0]  factory_test_port;
    logic [NIB_W-1:0]  rdata;
  } ikt_state_s;

  ikt_state_s s;
  ikt_state_s next_s;
  logic       pulse_10hz;
  logic       tick_2hz;
  logic       ctrl_wr;
  logic       clk_reset;

  function automatic logic hit(input logic stb, input logic [3:0] code, input logic [3:0] want);
    hit = stb && (code == want);
  endfunction

  function automatic logic [NIB_W-1:0] nibble(input logic [WORD_W-1:0] w, input logic [1:0] i);
    nibble = w[i*NIB_W +: NIB_W];
  endfunction

  assign ctrl_wr   = hit(port_req.io_out, port_req.code, CN_CTRL);
  assign clk_reset = (ctrl_wr && port_req.wdata[BIT_CLK_RST]) || clock_stop_instr;

  // Clock stop also restarts the dividers; the timer flag is not trusted afterwards
  ikt_timebase #(
    .TICK_CYC (TICK_CYC)
  ) u_timebase (
    .clock      (clock),
    .rst        (rst),
    .clear      (clk_reset),
    .pulse_10hz (pulse_10hz),
    .tick_2hz   (tick_2hz)
  );

  always_comb begin
    logic              strobe;
    logic              restart;
    logic [NIB_W-1:0]  rd;
    logic [NIB_W-1:0]  status;
    strobe  = 1'b0;
    restart = 1'b0;
    rd      = '0;
    status  = '0;
    next_s  = s;

    // Pin synchronisers; a change is taken once stages two and three agree
    next_s.key_s1 = key_line;
    next_s.key_s2 = s.key_s1;
    next_s.key_s3 = s.key_s2;
    if (s.key_s2 == s.key_s3) begin
      next_s.key_f = s.key_s3;
    end
    next_s.inh_s1 = inhibit_pin;
    next_s.inh_s2 = s.inh_s1;
    next_s.inh_s3 = s.inh_s2;
    if (s.inh_s2 == s.inh_s3) begin
      next_s.inh_f = s.inh_s3;
    end

    // Digit scan with a strobe on the fifth of the six cycles of each digit slot
    strobe = (s.cyc == DIGIT_MID);
    if (s.cyc == DIGIT_LAST) begin
      next_s.cyc = '0;
      next_s.dig = (s.dig == DIGIT_MAX) ? '0 : s.dig + 1'b1;
    end else begin
      next_s.cyc = s.cyc + 1'b1;
    end
    next_s.digit_out = DIGITS'(1) << next_s.dig;

    // Port writes; each register holds until its write, lookup or capture, and the timer flag also sets on tick_2hz
    if (hit(port_req.io_out, port_req.code, CN_INDIR)) begin
      next_s.indirect_low_address_reg = port_req.wdata;
    end
    if (hit(port_req.io_out, port_req.code, CN_SEL_LO)) begin
      next_s.sel[3:0] = port_req.wdata;
    end
    if (hit(port_req.io_out, port_req.code, CN_SEL_HI)) begin
      next_s.sel[DIGITS-1:4] = port_req.wdata[2:0];
    end
    if (hit(port_req.key_out, port_req.code, CN_TEST)) begin
      // Normal software only ever writes zero here
      next_s.factory_test_port = port_req.wdata;
    end
    if (program_word_lookup) begin
      next_s.program_word_data_reg = program_word;
    end
    if (ctrl_wr && port_req.wdata[BIT_INH_CAP]) begin
      next_s.inhibit_input_latch = s.inh_f;
    end
    // Set wins over a clear in the same cycle; reading never clears
    next_s.timer_2hz = tick_2hz || (s.timer_2hz && !(ctrl_wr && port_req.wdata[BIT_TMR_CLR]));
    restart = ctrl_wr && port_req.wdata[BIT_KEY_RST];

    // Key scan sequence
    case (s.st)
      KS_IDLE: begin
        next_s.st = KS_IDLE;
      end
      KS_SAMPLE: begin
        // Zero means no key: keep sampling on later strobes
        if (strobe && s.sel[s.dig] && (s.key_f != '0)) begin
          next_s.key_val = s.key_f;
          next_s.result  = '0;
          next_s.chk_cnt = '0;
          next_s.st      = KS_CHECK;
        end
      end
      KS_CHECK: begin
        // One result per digit over a full round, masked by selection
        if (strobe) begin
          next_s.result[s.dig] = s.sel[s.dig] && (s.key_f != '0);
          next_s.chk_cnt       = s.chk_cnt + 1'b1;
          if (s.chk_cnt == DIGIT_MAX) begin
            next_s.key_on = 1'b1;
            next_s.st     = KS_HOLD;
          end
        end
      end
      KS_HOLD: begin
        next_s.st = KS_HOLD;
      end
      default: begin
        next_s.st = KS_IDLE;
      end
    endcase
    if (restart) begin
      // Restart wins over a completing check: the new scan must start clean
      next_s.key_on = 1'b0;
      next_s.st     = KS_SAMPLE;
    end

    // Read side
    status[ST_KEY0]   = s.key_f[0];
    status[ST_KEY_ON] = s.key_on;
    status[ST_TMR]    = s.timer_2hz;
    status[ST_10HZ]   = pulse_10hz;
    if (port_req.io_in) begin
      case (port_req.code)
        CN_INH:    rd = {{(NIB_W-1){1'b0}}, s.inhibit_input_latch};
        CN_CTRL:   rd = status;
        CN_SEL_LO: rd = s.sel[3:0];
        CN_SEL_HI: rd = {1'b0, s.sel[DIGITS-1:4]};
        default:   rd = '0;
      endcase
      next_s.rdata = rd;
    end else if (port_req.key_in) begin
      case (port_req.code)
        CN_RES_LO: rd = s.result[3:0];
        CN_RES_HI: rd = {1'b0, s.result[DIGITS-1:4]};
        CN_KEYLAT: rd = s.key_val;
        default:   rd = (port_req.code[3:2] == DREG_HI2) ?
                        nibble(s.program_word_data_reg, port_req.code[1:0]) : '0;
      endcase
      next_s.rdata = rd;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s    <= '0;
      s.st <= KS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Only indirect moves see the register; all sixteen low addresses reachable
  assign mem_low_addr      = indirect_move ? s.indirect_low_address_reg : row_address;
  assign port_rdata        = s.rdata;
  assign digit_line        = s.digit_out;
  assign factory_test_port = s.factory_test_port;

  chk_restart_clears_on: assert property (@(posedge clock) disable iff (rst)
    (ctrl_wr && port_req.wdata[BIT_KEY_RST]) |=> (!s.key_on && s.st == KS_SAMPLE))
    else $error("key restart did not clear key pressed");

  chk_key_hold: assert property (@(posedge clock) disable iff (rst)
    (s.key_on && !(ctrl_wr && port_req.wdata[BIT_KEY_RST])) |=>
      (s.key_on && $stable(s.key_val) && $stable(s.result)))
    else $error("latched key data changed without restart");

  chk_latch_nonzero: assert property (@(posedge clock) disable iff (rst)
    (s.st == KS_SAMPLE) ##1 (s.st == KS_CHECK) |->
      (s.key_val != '0 && $past(s.sel[s.dig]) && $past(s.cyc) == DIGIT_MID))
    else $error("key latched on zero value or deselected digit");

  chk_result_masked: assert property (@(posedge clock) disable iff (rst)
    $rose(s.key_on) |-> ((s.result & ~s.sel) == '0 && $past(s.st) == KS_CHECK))
    else $error("key pressed set without full masked check");

  chk_indirect_write: assert property (@(posedge clock) disable iff (rst)
    hit(port_req.io_out, port_req.code, CN_INDIR) |=>
      s.indirect_low_address_reg == $past(port_req.wdata))
    else $error("indirect register not written");

  chk_addr_select: assert property (@(posedge clock) disable iff (rst)
    !indirect_move |-> mem_low_addr == row_address)
    else $error("indirect register leaked into plain addressing");

  chk_timer_sticky: assert property (@(posedge clock) disable iff (rst)
    (s.timer_2hz && !(ctrl_wr && port_req.wdata[BIT_TMR_CLR])) |=> s.timer_2hz)
    else $error("timer flag lost without clear");

  chk_timer_clear: assert property (@(posedge clock) disable iff (rst)
    (ctrl_wr && port_req.wdata[BIT_TMR_CLR] && !tick_2hz) |=> !s.timer_2hz)
    else $error("timer flag not cleared");

  chk_inhibit_capture: assert property (@(posedge clock) disable iff (rst)
    (ctrl_wr && port_req.wdata[BIT_INH_CAP]) |=> s.inhibit_input_latch == $past(s.inh_f))
    else $error("inhibit latch not refreshed");

  chk_lookup_load: assert property (@(posedge clock) disable iff (rst)
    program_word_lookup |=> s.program_word_data_reg == $past(program_word))
    else $error("program word not loaded");

  chk_rdata_hold: assert property (@(posedge clock) disable iff (rst)
    !(port_req.io_in || port_req.key_in) |=> $stable(port_rdata))
    else $error("read data changed without a read");

  chk_test_hold: assert property (@(posedge clock) disable iff (rst)
    !hit(port_req.key_out, port_req.code, CN_TEST) |=> $stable(factory_test_port))
    else $error("test port changed without its write");

  chk_inhibit_hold: assert property (@(posedge clock) disable iff (rst)
    !(ctrl_wr && port_req.wdata[BIT_INH_CAP]) |=> $stable(s.inhibit_input_latch))
    else $error("inhibit latch changed without capture");

  chk_indirect_hold: assert property (@(posedge clock) disable iff (rst)
    !hit(port_req.io_out, port_req.code, CN_INDIR) |=> $stable(s.indirect_low_address_reg))
    else $error("indirect register changed without its write");

  chk_digit_onehot: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) |-> $onehot(digit_line))
    else $error("digit scan not one hot");
endmodule

// ### verilog/ikt_timebase.sv
/*
 * Time base: 10 ms prescaler, 10 Hz interval pulse and 2 Hz set pulse.
 * Assumes clear is a one-cycle pulse from the port logic on the same clock.
 */
`timescale 1ns/1ps
module ikt_timebase import ikt_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clear,
  output logic      pulse_10hz,
  output logic      tick_2hz
);
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [TB_W-1:0]  cnt10;
    logic [TB_W-1:0]  cnt2;
    logic             p10;
    logic             t2;
  } ikt_tb_s;

  ikt_tb_s s;
  ikt_tb_s next_s;

  always_comb begin
    next_s    = s;
    next_s.t2 = 1'b0;
    if (clear) begin
      // Every stage below 50 Hz restarts so clock time can be set
      next_s.pre   = '0;
      next_s.cnt10 = '0;
      next_s.cnt2  = '0;
    end else if (s.pre == PRE_W'(TICK_CYC - 1)) begin
      next_s.pre   = '0;
      next_s.cnt10 = (s.cnt10 == TB_W'(TICKS_10HZ - 1)) ? '0 : s.cnt10 + 1'b1;
      if (s.cnt2 == TB_W'(TICKS_2HZ - 1)) begin
        next_s.cnt2 = '0;
        next_s.t2   = 1'b1;
      end else begin
        next_s.cnt2 = s.cnt2 + 1'b1;
      end
    end else begin
      next_s.pre = s.pre + 1'b1;
    end
    // 60 % high within each 100 ms period
    next_s.p10 = (next_s.cnt10 < TB_W'(HIGH_10HZ));
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse_10hz = s.p10;
  assign tick_2hz   = s.t2;

  chk_clear_restarts: assert property (@(posedge clock) disable iff (rst)
    clear |=> (s.pre == '0 && s.cnt10 == '0 && pulse_10hz))
    else $error("time base not restarted by clock reset");
endmodule
